// ### logic/tmq_pkg.sv
// Purpose: Shared types of the timer block.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Constants live in tmq_regs.svh; this package holds types only.
package tmq_pkg;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    // Gray order along normal -> armed -> skip; skip -> normal changes both bits.
    typedef enum logic [1:0] {
        TMQ_PWM_NORMAL = 2'h0,
        TMQ_PWM_ARMED = 2'h1,
        TMQ_PWM_SKIP = 2'h3
    } tmq_pwm_state_type;

    typedef logic [7:0] tmq_byte_type;
    typedef logic [15:0] tmq_word_type;

endpackage : tmq_pkg

// ### logic/tmq_prescaler.sv
// Purpose: Divides mclk into a one-cycle counter tick of 1, 1/2, 1/4 or 1/8.
// Assumes: sel is stable between writes; run low holds the divider at zero.
// Notes: Tick is combinational from the divider state, sel and run.
`include "tmq_regs.svh"

module tmq_prescaler (
    input wire logic mclk, // System clock.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic run, // High while the timer counts.
    input wire logic [1:0] sel, // Divide select, 2**sel.
    output logic tick // One-cycle counting enable.
);

    logic [2:0] div_q;
    logic [2:0] sel_mask;

    // Mask of divider bits that must all be set for a tick.
    function automatic logic [2:0] div_mask(input logic [1:0] s);
        case (s)
            2'h0: div_mask = 3'h0;
            2'h1: div_mask = 3'h1;
            2'h2: div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
    endfunction : div_mask

    assign sel_mask = div_mask(sel);

    // Divider restarts when halted so the first tick after enable is a full period.
    always_ff @(posedge mclk) begin
        if (reset || !run) begin
            div_q <= `TMQ_PSC_RESET;
        end else if (tick) begin
            div_q <= `TMQ_PSC_RESET;
        end else begin
            div_q <= div_q + `TMQ_PSC_STEP;
        end
    end

    assign tick = run && ((div_q & sel_mask) == sel_mask);

endmodule : tmq_prescaler

// ### logic/tmq_regs.svh
// Purpose: Register offsets, field positions and reset values of the timer block.
// Assumes: Eight-bit register port with a four-bit address.
// Notes: Definitions only; included by every file that decodes registers.
`ifndef TMQ_REGS_SVH
`define TMQ_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TMQ_OFF_CTRL_ONE 4'h0
`define TMQ_OFF_CTRL_TWO 4'h1
`define TMQ_OFF_CTRL_STATUS 4'h2
`define TMQ_OFF_CMP_HIGH 4'h3
`define TMQ_OFF_CMP_LOW 4'h4
`define TMQ_OFF_CNT_HIGH 4'h5
`define TMQ_OFF_CNT_LOW 4'h6
`define TMQ_OFF_IRQ_MASK 4'h7

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TMQ_BIT_MATCH_LVL 0
`define TMQ_BIT_PEREND_LVL 1
`define TMQ_BIT_CMP_IE 6
`define TMQ_BIT_PWM_EN 4
`define TMQ_PSC_LSB 0
`define TMQ_PSC_MSB 1
`define TMQ_BIT_HALT 6
`define TMQ_BIT_CMP_FLAG 3
`define TMQ_BIT_PER_FLAG 5
`define TMQ_BIT_LOCK 0
`define TMQ_FLAG_CMP 0
`define TMQ_FLAG_PER 1

// ----------------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------------
`define TMQ_SKIP_VALUE 16'hFFFC
`define TMQ_CNT_RESET 16'h0000
`define TMQ_CNT_TOP 16'hFFFF
`define TMQ_CNT_STEP 16'h0001
`define TMQ_CMP_RESET 16'hFFFF
`define TMQ_CMP_HIGH_RESET 8'hFF
`define TMQ_CTRL_RESET 8'h00
`define TMQ_MASK_RESET 8'hFF
`define TMQ_BYTE_ZERO 8'h00
`define TMQ_PSC_RESET 3'h0
`define TMQ_PSC_STEP 3'h1

`endif

// ### logic/tmq_sticky_flag.sv
// Purpose: One sticky event flag with write-one-to-clear and an optional lock.
// Assumes: Callers give single-cycle set, clear, lock and unlock strobes.
// Notes: A set in the clearing cycle wins; a locked flag ignores clears.
`include "tmq_regs.svh"

module tmq_sticky_flag (
    input wire logic mclk, // System clock.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic set_evt, // Event that raises the flag.
    input wire logic clr_req, // Software clear strobe.
    input wire logic lock_evt, // Condition that freezes the flag.
    input wire logic unlock, // Condition that releases the lock.
    output logic flag, // Flag state, from a register.
    output logic locked // Lock state, from a register.
);

    logic flag_q;
    logic locked_q;

    // Lock is held until the releasing condition arrives.
    always_ff @(posedge mclk) begin
        if (reset) begin
            locked_q <= 1'b0;
        end else if (lock_evt) begin
            locked_q <= 1'b1;
        end else if (unlock) begin
            locked_q <= 1'b0;
        end
    end

    // Set has priority so no event is lost to a racing clear.
    always_ff @(posedge mclk) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else if (set_evt) begin
            flag_q <= 1'b1;
        end else if (clr_req && !locked_q) begin
            flag_q <= 1'b0;
        end
    end

    assign flag = flag_q;
    assign locked = locked_q;

endmodule : tmq_sticky_flag

// ### logic/tmq_timer16.sv
// What this block does
// - In PWM mode, loading FFFCh as the compare value makes the timer skip the next pulse.
// - In the skipped period the output holds one level chosen by the period-end level setting.
// - Halting the timer in the cycle of a compare event locks the compare flag until restart.
// - A locked flag with its interrupt enabled keeps the interrupt request high.
//
// Purpose: 16-bit timer with output compare, PWM output and its known quirks.
// Assumes: Eight-bit register port, single cycle strobes, read data one cycle later.
// Notes: The counter wraps at FFFFh; that wrap is the PWM period boundary.
//
// The strobed register port and the placing of the registers were left to the implementer.
`include "tmq_regs.svh"

module tmq_timer16 (
    input wire logic mclk, // System clock, 200 MHz.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic [3:0] reg_addr, // Register address.
    input wire logic [7:0] reg_wdata, // Write data.
    input wire logic reg_wr, // Write strobe.
    input wire logic reg_rd, // Read strobe.
    output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd.
    output logic pwm_out, // Compare / PWM output pin.
    output logic irq // Interrupt request, level.
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    tmq_pkg::tmq_byte_type timer_a_control_one_q;
    tmq_pkg::tmq_byte_type ctrl_two_q;
    tmq_pkg::tmq_byte_type irq_mask_q;
    tmq_pkg::tmq_byte_type rdata_q;
    tmq_pkg::tmq_byte_type rdata_d;
    tmq_pkg::tmq_byte_type compare_one_high_byte_q;
    tmq_pkg::tmq_word_type compare_one_value_q;
    tmq_pkg::tmq_word_type cmp_active_q;
    tmq_pkg::tmq_word_type count_q;
    tmq_pkg::tmq_pwm_state_type pwm_state_q;
    tmq_pkg::tmq_pwm_state_type pwm_state_d;
    logic timer_halt_bit_q;
    logic pwm_q;
    logic tick;
    logic pwm_mode;
    logic cmp_event;
    logic wrap_event;
    logic csr_wr;
    logic cmp_low_wr;
    logic halt_set;
    logic halt_clear;
    logic new_cmp_load;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    logic [1:0] flag_lock;
    logic [1:0] flag_unlock;
    logic [1:0] flag_q;
    logic [1:0] flag_locked;
    logic [1:0] flag_mask;

    // Write hit for one register; shared by every register process.
    function automatic logic wr_hit(input logic wr, input logic [3:0] a,
                                    input logic [3:0] off);
        wr_hit = wr && (a == off);
    endfunction : wr_hit

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    assign csr_wr = wr_hit(reg_wr, reg_addr, `TMQ_OFF_CTRL_STATUS);
    assign cmp_low_wr = wr_hit(reg_wr, reg_addr, `TMQ_OFF_CMP_LOW);
    assign pwm_mode = ctrl_two_q[`TMQ_BIT_PWM_EN];

    // Control one holds the compare interrupt enable and both output levels.
    always_ff @(posedge mclk) begin
        if (reset) begin
            timer_a_control_one_q <= `TMQ_CTRL_RESET;
        end else if (wr_hit(reg_wr, reg_addr, `TMQ_OFF_CTRL_ONE)) begin
            timer_a_control_one_q <= reg_wdata;
        end
    end

    // Control two holds PWM mode and the prescaler select.
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_two_q <= `TMQ_CTRL_RESET;
        end else if (wr_hit(reg_wr, reg_addr, `TMQ_OFF_CTRL_TWO)) begin
            ctrl_two_q <= reg_wdata;
        end
    end

    // Interrupt mask, same layout as the flag bits of control/status.
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_mask_q <= `TMQ_MASK_RESET;
        end else if (wr_hit(reg_wr, reg_addr, `TMQ_OFF_IRQ_MASK)) begin
            irq_mask_q <= reg_wdata;
        end
    end

    // Halt bit; the counter sees the new value from the next clock on.
    always_ff @(posedge mclk) begin
        if (reset) begin
            timer_halt_bit_q <= 1'b0;
        end else if (csr_wr) begin
            timer_halt_bit_q <= reg_wdata[`TMQ_BIT_HALT];
        end
    end

    assign halt_set = csr_wr && reg_wdata[`TMQ_BIT_HALT] && !timer_halt_bit_q;
    assign halt_clear = csr_wr && !reg_wdata[`TMQ_BIT_HALT] && timer_halt_bit_q;

    // ------------------------------------------------------------------------
    // Compare value
    // ------------------------------------------------------------------------
    // High byte is staged; the low byte write commits the full 16-bit value,
    // so the comparator never sees a half-written word.
    always_ff @(posedge mclk) begin
        if (reset) begin
            compare_one_high_byte_q <= `TMQ_CMP_HIGH_RESET;
        end else if (wr_hit(reg_wr, reg_addr, `TMQ_OFF_CMP_HIGH)) begin
            compare_one_high_byte_q <= reg_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            compare_one_value_q <= `TMQ_CMP_RESET;
        end else if (cmp_low_wr) begin
            compare_one_value_q <= {compare_one_high_byte_q, reg_wdata};
        end
    end

    assign new_cmp_load = cmp_low_wr && pwm_mode
        && ({compare_one_high_byte_q, reg_wdata} == `TMQ_SKIP_VALUE);

    // In PWM mode the compare value takes effect at a period boundary, which
    // keeps each pulse glitch free; otherwise it follows the register at once.
    always_ff @(posedge mclk) begin
        if (reset) begin
            cmp_active_q <= `TMQ_CMP_RESET;
        end else if (!pwm_mode || wrap_event) begin
            cmp_active_q <= compare_one_value_q;
        end
    end

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    tmq_prescaler u_prescaler (
        .mclk(mclk),
        .reset(reset),
        .run(!timer_halt_bit_q),
        .sel(ctrl_two_q[`TMQ_PSC_MSB:`TMQ_PSC_LSB]),
        .tick(tick)
    );

    // Counter holds its value while halted and resumes from there.
    always_ff @(posedge mclk) begin
        if (reset) begin
            count_q <= `TMQ_CNT_RESET;
        end else if (tick) begin
            count_q <= count_q + `TMQ_CNT_STEP;
        end
    end

    assign cmp_event = tick && (count_q == cmp_active_q);
    assign wrap_event = tick && (count_q == `TMQ_CNT_TOP);

    // ------------------------------------------------------------------------
    // PWM skip sequencing
    // ------------------------------------------------------------------------
    // A FFFCh load arms the skip; the following period loses its pulse.
    always_comb begin
        pwm_state_d = pwm_state_q;
        case (pwm_state_q)
            tmq_pkg::TMQ_PWM_NORMAL: begin
                if (new_cmp_load) begin
                    pwm_state_d = tmq_pkg::TMQ_PWM_ARMED;
                end
            end
            tmq_pkg::TMQ_PWM_ARMED: begin
                if (wrap_event) begin
                    pwm_state_d = tmq_pkg::TMQ_PWM_SKIP;
                end
            end
            tmq_pkg::TMQ_PWM_SKIP: begin
                if (wrap_event) begin
                    pwm_state_d = new_cmp_load ? tmq_pkg::TMQ_PWM_ARMED
                                               : tmq_pkg::TMQ_PWM_NORMAL;
                end
            end
            default: begin
                pwm_state_d = tmq_pkg::TMQ_PWM_NORMAL;
            end
        endcase
        if (!pwm_mode) begin
            pwm_state_d = tmq_pkg::TMQ_PWM_NORMAL;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pwm_state_q <= tmq_pkg::TMQ_PWM_NORMAL;
        end else begin
            pwm_state_q <= pwm_state_d;
        end
    end

    // ------------------------------------------------------------------------
    // Output pin
    // ------------------------------------------------------------------------
    // In PWM mode the boundary drives the period-end level; a match drives the match level.
    // In the skipped period the match is ignored, so the pin stays at the
    // period-end level all period: fully on or fully off by the settings.
    always_ff @(posedge mclk) begin
        if (reset) begin
            pwm_q <= 1'b0;
        end else if (pwm_mode) begin
            if (wrap_event) begin
                pwm_q <= timer_a_control_one_q[`TMQ_BIT_PEREND_LVL];
            end else if (cmp_event && pwm_state_q != tmq_pkg::TMQ_PWM_SKIP) begin
                pwm_q <= timer_a_control_one_q[`TMQ_BIT_MATCH_LVL];
            end
        end else if (cmp_event) begin
            pwm_q <= timer_a_control_one_q[`TMQ_BIT_MATCH_LVL];
        end
    end

    assign pwm_out = pwm_q;

    // ------------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------------
    // Only the compare flag has the halt-race lock; the period flag never locks.
    assign flag_set[`TMQ_FLAG_CMP] = cmp_event;
    assign flag_set[`TMQ_FLAG_PER] = wrap_event;
    assign flag_clr[`TMQ_FLAG_CMP] = csr_wr && reg_wdata[`TMQ_BIT_CMP_FLAG];
    assign flag_clr[`TMQ_FLAG_PER] = csr_wr && reg_wdata[`TMQ_BIT_PER_FLAG];
    assign flag_lock[`TMQ_FLAG_CMP] = halt_set && cmp_event;
    assign flag_lock[`TMQ_FLAG_PER] = 1'b0;
    assign flag_unlock[`TMQ_FLAG_CMP] = halt_clear;
    assign flag_unlock[`TMQ_FLAG_PER] = 1'b0;
    assign flag_mask[`TMQ_FLAG_CMP] = irq_mask_q[`TMQ_BIT_CMP_FLAG];
    assign flag_mask[`TMQ_FLAG_PER] = irq_mask_q[`TMQ_BIT_PER_FLAG];

    generate
        for (genvar i = 0; i < 2; i++) begin : g_flag
            tmq_sticky_flag u_flag (
                .mclk(mclk),
                .reset(reset),
                .set_evt(flag_set[i]),
                .clr_req(flag_clr[i]),
                .lock_evt(flag_lock[i]),
                .unlock(flag_unlock[i]),
                .flag(flag_q[i]),
                .locked(flag_locked[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------------------
    // A locked compare flag cannot be cleared, so with the enable set the
    // request stays high; software must drop the enable before halting.
    assign irq = (flag_q[`TMQ_FLAG_CMP] && flag_mask[`TMQ_FLAG_CMP]
                  && timer_a_control_one_q[`TMQ_BIT_CMP_IE])
                 || (flag_q[`TMQ_FLAG_PER] && flag_mask[`TMQ_FLAG_PER]);

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Control/status also shows the lock in bit 0 for diagnosis.
    always_comb begin
        rdata_d = `TMQ_BYTE_ZERO;
        case (reg_addr)
            `TMQ_OFF_CTRL_ONE: rdata_d = timer_a_control_one_q;
            `TMQ_OFF_CTRL_TWO: rdata_d = ctrl_two_q;
            `TMQ_OFF_CTRL_STATUS: begin
                rdata_d[`TMQ_BIT_HALT] = timer_halt_bit_q;
                rdata_d[`TMQ_BIT_CMP_FLAG] = flag_q[`TMQ_FLAG_CMP];
                rdata_d[`TMQ_BIT_PER_FLAG] = flag_q[`TMQ_FLAG_PER];
                rdata_d[`TMQ_BIT_LOCK] = flag_locked[`TMQ_FLAG_CMP];
            end
            `TMQ_OFF_CMP_HIGH: rdata_d = compare_one_value_q[15:8];
            `TMQ_OFF_CMP_LOW: rdata_d = compare_one_value_q[7:0];
            `TMQ_OFF_CNT_HIGH: rdata_d = count_q[15:8];
            `TMQ_OFF_CNT_LOW: rdata_d = count_q[7:0];
            `TMQ_OFF_IRQ_MASK: rdata_d = irq_mask_q;
            default: rdata_d = `TMQ_BYTE_ZERO;
        endcase
    end

    // Read data stands only in the cycle after the strobe, zero otherwise.
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_q <= `TMQ_BYTE_ZERO;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= `TMQ_BYTE_ZERO;
        end
    end

    assign reg_rdata = rdata_q;

endmodule : tmq_timer16

// ### testbench/tb.sv
// Purpose: Self-checking bench for the compare and PWM timer.
// Assumes: Prescale of one, so the counter steps every clock and a period is 65536 clocks.
// Notes: The skipped pulse needs a wrap and one full period, so the run is about 131k clocks.
`include "tmq_regs.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic pwm_out;
    logic irq;
    int num_errors = 0;
    int checked = 0;
    int cyc = 0;
    int t0;
    logic [7:0] d;
    logic [3:0] ra [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'hC};
    logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00};

    tmq_timer16 u_dut (
        .mclk(mclk),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .pwm_out(pwm_out),
        .irq(irq)
    );

    // 200 MHz clock and a free cycle count for measuring pin timing.
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    // ------------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------------
    // Each access starts at an edge, so back-to-back calls never touch a strobe twice at once.
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        v = reg_rdata;
    endtask : rd

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // Bounded wait for the pin; a timeout ends the run.
    task automatic wait_pin(input logic lvl, input int bound);
        int k;
        for (k = 0; k < bound && pwm_out !== lvl; k++) @(posedge mclk);
        if (pwm_out !== lvl) begin
            num_errors++;
            $display("CHECK FAILED pin wait expected %0h seen %0h", lvl, pwm_out);
            stop_test();
        end
    endtask : wait_pin

    // Halt the timer in the very cycle its compare matches, then restart in the safe order.
    task automatic lock_run(input logic [7:0] ie, input logic exp_irq);
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] lo2;
        logic [15:0] n;
        wr(`TMQ_OFF_CTRL_ONE, ie);
        wr(`TMQ_OFF_CTRL_STATUS, 8'h40);
        rd(`TMQ_OFF_CNT_HIGH, hi);
        rd(`TMQ_OFF_CNT_LOW, lo);
        rd(`TMQ_OFF_CNT_LOW, lo2);
        chk("halted count", {24'h0, lo}, {24'h0, lo2});
        n = {hi, lo} + 16'h0001;
        wr(`TMQ_OFF_CMP_HIGH, n[15:8]);
        wr(`TMQ_OFF_CMP_LOW, n[7:0]);
        wr(`TMQ_OFF_CTRL_STATUS, 8'h00);
        wr(`TMQ_OFF_CTRL_STATUS, 8'h40);
        rd(`TMQ_OFF_CTRL_STATUS, d);
        chk("locked status", 32'h49, {24'h0, d});
        wr(`TMQ_OFF_CTRL_STATUS, 8'h48);
        rd(`TMQ_OFF_CTRL_STATUS, d);
        chk("status after clear", 32'h49, {24'h0, d});
        chk("irq while locked", {31'h0, exp_irq}, {31'h0, irq});
        wr(`TMQ_OFF_CTRL_STATUS, 8'h00);
        wr(`TMQ_OFF_CTRL_STATUS, 8'h08);
        wr(`TMQ_OFF_CTRL_ONE, 8'h40);
        rd(`TMQ_OFF_CTRL_STATUS, d);
        chk("status after restart", 32'h00, {24'h0, d});
        chk("irq after restart", 32'h0, {31'h0, irq});
    endtask : lock_run

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    // Reset values, two lock runs, interrupt masking and the skipped first PWM pulse.
    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        foreach (ra[i]) begin
            rd(ra[i], d);
            chk("reset value", {24'h0, rv[i]}, {24'h0, d});
        end
        lock_run(8'h40, 1'b1);
        lock_run(8'h00, 1'b0);
        wr(`TMQ_OFF_CTRL_ONE, 8'h02);
        wr(`TMQ_OFF_CTRL_TWO, 8'h10);
        wr(`TMQ_OFF_CMP_HIGH, 8'hFF);
        wr(`TMQ_OFF_CMP_LOW, 8'hFC);
        wait_pin(1'b1, 70000);
        t0 = cyc;
        chk("period irq", 32'h1, {31'h0, irq});
        rd(`TMQ_OFF_CTRL_STATUS, d);
        chk("period flag", 32'h20, {24'h0, d});
        wr(`TMQ_OFF_IRQ_MASK, 8'h08);
        rd(`TMQ_OFF_IRQ_MASK, d);
        chk("mask readback", 32'h08, {24'h0, d});
        chk("masked irq", 32'h0, {31'h0, irq});
        wr(`TMQ_OFF_CTRL_STATUS, 8'h20);
        wr(`TMQ_OFF_IRQ_MASK, 8'hFF);
        @(posedge mclk);
        chk("cleared irq", 32'h0, {31'h0, irq});
        // A small compare loaded in the skipped period takes over at its closing wrap.
        // This proves the skip without waiting out a third full period of the counter.
        wr(`TMQ_OFF_CMP_HIGH, 8'h00);
        wr(`TMQ_OFF_CMP_LOW, 8'h10);
        wait_pin(1'b0, 70000);
        chk("skipped pulse", 32'd65553, cyc - t0);
        rd(`TMQ_OFF_CNT_LOW, d);
        chk("count after match", 32'h13, {24'h0, d});
        stop_test();
    end
endmodule : tb

// ### testbench/tmq_timer16_checker.sv
// Purpose: Port-level assertions for the compare and PWM timer.
// Assumes: Register writes act from the clock after the strobe, reads answer one cycle later.
// Notes: Shadows of written controls stand in for state that the ports do not show.
`include "tmq_regs.svh"

module tmq_timer16_checker (
    input wire logic mclk, // System clock.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic [3:0] reg_addr, // Register address.
    input wire logic [7:0] reg_wdata, // Write data.
    input wire logic reg_wr, // Write strobe.
    input wire logic reg_rd, // Read strobe.
    input wire logic [7:0] reg_rdata, // Read data.
    input wire logic pwm_out, // Compare output pin.
    input wire logic irq // Interrupt request.
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    logic [7:0] ctl1_q;
    logic [7:0] mask_q;
    logic halt_q;

    // Shadow copies of the written controls; they land at the edge that takes the write.
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctl1_q <= 8'h00;
            mask_q <= 8'hFF;
            halt_q <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `TMQ_OFF_CTRL_ONE) ctl1_q <= reg_wdata;
            if (reg_addr == `TMQ_OFF_IRQ_MASK) mask_q <= reg_wdata;
            if (reg_addr == `TMQ_OFF_CTRL_STATUS) halt_q <= reg_wdata[6];
        end
    end

    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    property p_unmapped;
        reg_rd && reg_addr[3] |=> reg_rdata == 8'h00;
    endproperty
    property p_ctl_readback;
        reg_rd && reg_addr == `TMQ_OFF_CTRL_ONE |=> (reg_rdata & 8'h43) == ($past(ctl1_q) & 8'h43);
    endproperty
    property p_mask_readback;
        reg_rd && reg_addr == `TMQ_OFF_IRQ_MASK |=> (reg_rdata & 8'h28) == ($past(mask_q) & 8'h28);
    endproperty
    property p_halt_readback;
        reg_rd && reg_addr == `TMQ_OFF_CTRL_STATUS |=> reg_rdata[6] == $past(halt_q);
    endproperty
    // A halted counter reads the same low byte on two reads three cycles apart.
    property p_count_frozen;
        (reg_rd && reg_addr == `TMQ_OFF_CNT_LOW && halt_q) ##1 halt_q [*2]
            ##1 (reg_rd && reg_addr == `TMQ_OFF_CNT_LOW && halt_q)
            |=> reg_rdata == $past(reg_rdata, 3);
    endproperty
    property p_lock_keeps_flag;
        (reg_rd && reg_addr == `TMQ_OFF_CTRL_STATUS) ##1 (reg_rdata[0] && reg_rdata[3])
            ##2 (reg_wr && reg_addr == `TMQ_OFF_CTRL_STATUS && reg_wdata[6])
            ##2 (reg_rd && reg_addr == `TMQ_OFF_CTRL_STATUS) |=> reg_rdata[3];
    endproperty
    property p_irq_locked;
        (reg_rd && reg_addr == `TMQ_OFF_CTRL_STATUS)
            ##1 (reg_rdata[0] && halt_q && ctl1_q[6] && mask_q[3]) |-> irq;
    endproperty
    property p_irq_cause;
        irq |-> (ctl1_q[6] && mask_q[3]) || mask_q[5];
    endproperty

    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_ctl_readback: assert property (p_ctl_readback) else $error("control one readback");
    a_mask_readback: assert property (p_mask_readback) else $error("mask readback");
    a_halt_readback: assert property (p_halt_readback) else $error("halt readback");
    a_count_frozen: assert property (p_count_frozen) else $error("counter moved");
    a_lock_keeps_flag: assert property (p_lock_keeps_flag) else $error("lock lost");
    a_irq_locked: assert property (p_irq_locked) else $error("irq low while locked");
    a_irq_cause: assert property (p_irq_cause) else $error("irq without enable");

    c_lock: cover property ((reg_rd && reg_addr == `TMQ_OFF_CTRL_STATUS) ##1 reg_rdata[0]);
    c_irq: cover property ($rose(irq));
    c_pwm_fall: cover property ($fell(pwm_out));
endmodule : tmq_timer16_checker

bind tmq_timer16 tmq_timer16_checker u_chk (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pwm_out(pwm_out), .irq(irq));
